// *** common/bgex_defs.svh ***
`ifndef BGEX_DEFS_SVH
`define BGEX_DEFS_SVH

// Register port widths.
`define BGEX_ADDR_W        8
`define BGEX_DATA_W        8

// Register offsets on the register port.
`define BGEX_OFS_E1_IN_LO  8'h00
`define BGEX_OFS_E1_IN_HI  8'h01
`define BGEX_OFS_E1_OUT_LO 8'h02
`define BGEX_OFS_E1_OUT_HI 8'h03
`define BGEX_OFS_E1_DIR_LO 8'h04
`define BGEX_OFS_E1_DIR_HI 8'h05
`define BGEX_OFS_E2_IN_LO  8'h06
`define BGEX_OFS_E2_IN_HI  8'h07

// Reset values of the writable registers.
`define BGEX_RST_DIR_LO    8'h00
`define BGEX_RST_DIR_HI    8'h00
`define BGEX_RST_OUT_LO    8'h00
`define BGEX_RST_OUT_HI    8'h00

// Value of reserved and unmapped read bits.
`define BGEX_RSVD_VAL      8'h00

// Field positions in the low input register of the second expander.
`define BGEX_E2L_SAT_EN    2
`define BGEX_E2L_PROG_EN   3
`define BGEX_E2L_LINE16    4
`define BGEX_E2L_LAMP      5
`define BGEX_E2L_PLL_LOCK  6

// Field positions in the high input register of the second expander.
`define BGEX_E2H_NAND_WP   0
`define BGEX_E2H_EEPROM_WP 1
`define BGEX_E2H_DETECT    2
`define BGEX_E2H_IDENT0    3
`define BGEX_E2H_IDENT1    4
`define BGEX_E2H_IDENT2    5
`define BGEX_E2H_SCL       6
`define BGEX_E2H_SDA       7

`endif

// *** common/bgex_pkg.sv ***
package bgex_pkg;

    // One register byte.
    typedef logic [7:0] bgex_byte_t;

    // Register selected by an address.
    typedef enum {
        BGEX_SEL_NONE,
        BGEX_SEL_E1_IN_LO,
        BGEX_SEL_E1_IN_HI,
        BGEX_SEL_E1_OUT_LO,
        BGEX_SEL_E1_OUT_HI,
        BGEX_SEL_E1_DIR_LO,
        BGEX_SEL_E1_DIR_HI,
        BGEX_SEL_E2_IN_LO,
        BGEX_SEL_E2_IN_HI
    } bgex_sel_e;

endpackage

// *** src/bgex_byte_reg.sv ***
`timescale 1ns/1ns
`include "bgex_defs.svh"

// One software-writable byte; it holds its value while the clock enable is low.
module bgex_byte_reg
    import bgex_pkg::*;
#(
    parameter bgex_byte_t RST_VAL = `BGEX_RST_DIR_LO
) (
    // Clock, reset and freeze.
    input  wire logic clock_i,
    input  wire logic rst_b_i,
    input  wire logic clk_en_i,
    // Write side.
    input  wire logic       wr_i,
    input  wire bgex_byte_t wdata_i,
    // Stored value.
    output bgex_byte_t      value_o
);

    bgex_byte_t value_reg;

    // Writes land only on an enabled edge, so a frozen block ignores the strobe.
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            value_reg <= RST_VAL;
        end else if (clk_en_i && wr_i) begin
            value_reg <= wdata_i;
        end
    end

    assign value_o = value_reg;

endmodule

// *** src/bgex_pin_bank.sv ***
`timescale 1ns/1ns

// Pad control for a bank of two-way pins driven from direction and output bytes.
module bgex_pin_bank #(
    parameter int PIN_W = 16
) (
    // Register side.
    input  wire logic [PIN_W-1:0] dir_i,
    input  wire logic [PIN_W-1:0] out_i,
    // Pad side.
    output logic      [PIN_W-1:0] pin_o,
    output logic      [PIN_W-1:0] pin_oe_o
);

    generate
        if (PIN_W < 1 || PIN_W % 8 != 0) begin : g_bad_width
            $error("bgex_pin_bank: pin count must be a whole number of bytes");
        end
    endgenerate

    // A set direction bit turns the pad into an output; cleared leaves it an input.
    assign pin_oe_o = dir_i;
    // The stored level is parked on the pad only while it drives, so the
    // output never toggles on an undriven pin and wastes no power there.
    assign pin_o    = out_i & dir_i;

endmodule

// *** src/bgex_top.sv ***
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
`include "bgex_defs.svh"

// Summary of operation
// - A direction bit of zero makes its pin an input, one an output.
// - Low direction byte bit n steers first-expander pin n; fully read/write.
// - High direction byte at 05h steers pins 8 to 15; read/write.
// - High direction byte resets to zero, so pins 8 to 15 start as inputs.
// - Second expander low input at 06h is read-only; bits 2..6 sense lines.
// - Input bits return the live pin level: low reads zero, high reads one.
// - Writes to input registers change nothing.
// - High input at 07h: bit 0 NAND protect, 1 EEPROM protect, 2 detect.
// - Bits 6 and 7 of the high input return serial clock and data lines.
// - Output bits set the level a pin drives while configured as output.
module bgex_top
    import bgex_pkg::*;
#(
    parameter int PIN_W = 16
) (
    // Clock, reset and freeze.
    input  wire logic                    clock_i,
    input  wire logic                    rst_b_i,
    input  wire logic                    clk_en_i,
    // Register port.
    input  wire logic [`BGEX_ADDR_W-1:0] reg_addr_i,
    input  wire logic [`BGEX_DATA_W-1:0] reg_wdata_i,
    input  wire logic                    reg_wr_i,
    input  wire logic                    reg_rd_i,
    output logic      [`BGEX_DATA_W-1:0] reg_rdata_o,
    // First expander two-way pins.
    input  wire logic [PIN_W-1:0]        e1_pin_i,
    output logic      [PIN_W-1:0]        e1_pin_o,
    output logic      [PIN_W-1:0]        e1_pin_oe_o,
    // Second expander sensed lines, low register.
    input  wire logic                    satellite_receiver_enable_i,
    input  wire logic                    programming_voltage_enable_i,
    input  wire logic                    processor_line_sixteen_i,
    input  wire logic                    lock_indicator_lamp_i,
    input  wire logic                    processor_pll_lock_i,
    // Second expander sensed lines, high register.
    input  wire logic                    nand_write_protect_n_i,
    input  wire logic                    eeprom_write_protect_n_i,
    input  wire logic                    expansion_board_detect_i,
    input  wire logic                    expansion_board_ident_0_i,
    input  wire logic                    expansion_board_ident_1_i,
    input  wire logic                    expansion_board_ident_2_i,
    input  wire logic                    external_serial_clock_line_i,
    input  wire logic                    external_serial_data_line_i
);

    // The register map below is laid out for exactly two bytes of pins.
    generate
        if (PIN_W != 16) begin : g_bad_pins
            $error("bgex_top: the register map serves exactly sixteen pins");
        end
    endgenerate

    bgex_byte_t dir_lo;
    bgex_byte_t dir_hi;
    bgex_byte_t out_lo;
    bgex_byte_t out_hi;
    bgex_byte_t e2_in_lo;
    bgex_byte_t e2_in_hi;
    bgex_byte_t rdata_reg;
    bgex_byte_t rdata_next;
    bgex_sel_e  wr_sel;
    bgex_sel_e  rd_sel;

    // Address decode shared by the write and the read paths.
    function automatic bgex_sel_e decode(input logic [`BGEX_ADDR_W-1:0] addr);
        case (addr)
            `BGEX_OFS_E1_IN_LO:  decode = BGEX_SEL_E1_IN_LO;
            `BGEX_OFS_E1_IN_HI:  decode = BGEX_SEL_E1_IN_HI;
            `BGEX_OFS_E1_OUT_LO: decode = BGEX_SEL_E1_OUT_LO;
            `BGEX_OFS_E1_OUT_HI: decode = BGEX_SEL_E1_OUT_HI;
            `BGEX_OFS_E1_DIR_LO: decode = BGEX_SEL_E1_DIR_LO;
            `BGEX_OFS_E1_DIR_HI: decode = BGEX_SEL_E1_DIR_HI;
            `BGEX_OFS_E2_IN_LO:  decode = BGEX_SEL_E2_IN_LO;
            `BGEX_OFS_E2_IN_HI:  decode = BGEX_SEL_E2_IN_HI;
            default:             decode = BGEX_SEL_NONE;
        endcase
    endfunction

    // Each strobe is decoded only when it is asserted. The input offsets decode to
    // selects that no register loads on, so a write to them is simply dropped.
    assign wr_sel = reg_wr_i ? decode(reg_addr_i) : BGEX_SEL_NONE;
    assign rd_sel = reg_rd_i ? decode(reg_addr_i) : BGEX_SEL_NONE;

    // Direction bytes; both start as inputs after reset.
    bgex_byte_reg #(
        .RST_VAL (`BGEX_RST_DIR_LO)
    ) u_dir_lo (
        .clock_i  (clock_i),
        .rst_b_i  (rst_b_i),
        .clk_en_i (clk_en_i),
        .wr_i     (wr_sel == BGEX_SEL_E1_DIR_LO),
        .wdata_i  (reg_wdata_i),
        .value_o  (dir_lo)
    );

    bgex_byte_reg #(
        .RST_VAL (`BGEX_RST_DIR_HI)
    ) u_dir_hi (
        .clock_i  (clock_i),
        .rst_b_i  (rst_b_i),
        .clk_en_i (clk_en_i),
        .wr_i     (wr_sel == BGEX_SEL_E1_DIR_HI),
        .wdata_i  (reg_wdata_i),
        .value_o  (dir_hi)
    );

    // Output level bytes; they may be loaded before the pin is turned round.
    bgex_byte_reg #(
        .RST_VAL (`BGEX_RST_OUT_LO)
    ) u_out_lo (
        .clock_i  (clock_i),
        .rst_b_i  (rst_b_i),
        .clk_en_i (clk_en_i),
        .wr_i     (wr_sel == BGEX_SEL_E1_OUT_LO),
        .wdata_i  (reg_wdata_i),
        .value_o  (out_lo)
    );

    bgex_byte_reg #(
        .RST_VAL (`BGEX_RST_OUT_HI)
    ) u_out_hi (
        .clock_i  (clock_i),
        .rst_b_i  (rst_b_i),
        .clk_en_i (clk_en_i),
        .wr_i     (wr_sel == BGEX_SEL_E1_OUT_HI),
        .wdata_i  (reg_wdata_i),
        .value_o  (out_hi)
    );

    // Pad drive for the sixteen first-expander pins.
    bgex_pin_bank #(
        .PIN_W (PIN_W)
    ) u_pins (
        .dir_i    ({dir_hi, dir_lo}),
        .out_i    ({out_hi, out_lo}),
        .pin_o    (e1_pin_o),
        .pin_oe_o (e1_pin_oe_o)
    );

    // Live view of the second expander low lines; bits 0, 1 and 7 read zero.
    always_comb begin
        e2_in_lo                     = `BGEX_RSVD_VAL;
        e2_in_lo[`BGEX_E2L_SAT_EN]   = satellite_receiver_enable_i;
        e2_in_lo[`BGEX_E2L_PROG_EN]  = programming_voltage_enable_i;
        e2_in_lo[`BGEX_E2L_LINE16]   = processor_line_sixteen_i;
        e2_in_lo[`BGEX_E2L_LAMP]     = lock_indicator_lamp_i;
        e2_in_lo[`BGEX_E2L_PLL_LOCK] = processor_pll_lock_i;
    end

    // Live view of the second expander high lines.
    always_comb begin
        e2_in_hi                      = `BGEX_RSVD_VAL;
        e2_in_hi[`BGEX_E2H_NAND_WP]   = nand_write_protect_n_i;
        e2_in_hi[`BGEX_E2H_EEPROM_WP] = eeprom_write_protect_n_i;
        e2_in_hi[`BGEX_E2H_DETECT]    = expansion_board_detect_i;
        e2_in_hi[`BGEX_E2H_IDENT0]    = expansion_board_ident_0_i;
        e2_in_hi[`BGEX_E2H_IDENT1]    = expansion_board_ident_1_i;
        e2_in_hi[`BGEX_E2H_IDENT2]    = expansion_board_ident_2_i;
        e2_in_hi[`BGEX_E2H_SCL]       = external_serial_clock_line_i;
        e2_in_hi[`BGEX_E2H_SDA]       = external_serial_data_line_i;
    end

    // Read mux. Input registers sample the pins at the read edge, never a stored
    // copy, so software always sees the level of that cycle. The input and
    // unmapped offsets have no write path at all.
    always_comb begin
        case (rd_sel)
            BGEX_SEL_E1_IN_LO:  rdata_next = e1_pin_i[7:0];
            BGEX_SEL_E1_IN_HI:  rdata_next = e1_pin_i[15:8];
            BGEX_SEL_E1_OUT_LO: rdata_next = out_lo;
            BGEX_SEL_E1_OUT_HI: rdata_next = out_hi;
            BGEX_SEL_E1_DIR_LO: rdata_next = dir_lo;
            BGEX_SEL_E1_DIR_HI: rdata_next = dir_hi;
            BGEX_SEL_E2_IN_LO:  rdata_next = e2_in_lo;
            BGEX_SEL_E2_IN_HI:  rdata_next = e2_in_hi;
            default:            rdata_next = `BGEX_RSVD_VAL;
        endcase
    end

    // Read data stand until the next enabled edge after the strobe, then fall to zero.
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_reg <= `BGEX_RSVD_VAL;
        end else if (clk_en_i) begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_o = rdata_reg;

    default clocking bgex_cb @(posedge clock_i);
    endclocking

    default disable iff (!rst_b_i);

    // Both direction bytes are zero while reset is held.
    dir_reset_zero_a: assert property (
        disable iff (1'b0) !rst_b_i |-> (dir_hi == 8'h00 && dir_lo == 8'h00))
        else $error("direction bytes not zero under reset");

    // Pins drive exactly where direction bits are set.
    oe_follows_dir_a: assert property (
        e1_pin_oe_o == {dir_hi, dir_lo})
        else $error("pin enables differ from direction bytes");

    // A driving pin carries its output bit.
    drive_level_a: assert property (
        (e1_pin_o & e1_pin_oe_o) == ({out_hi, out_lo} & e1_pin_oe_o))
        else $error("driven pin level differs from output byte");

    // A low direction write is seen by a read of that byte in the very next cycle.
    dir_lo_rw_a: assert property (
        (clk_en_i && reg_wr_i && reg_addr_i == `BGEX_OFS_E1_DIR_LO) ##1
        (clk_en_i && reg_rd_i && reg_addr_i == `BGEX_OFS_E1_DIR_LO)
        |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("low direction write not read back");

    // A high direction write updates the high pin enables.
    dir_hi_write_a: assert property (
        clk_en_i && reg_wr_i && reg_addr_i == `BGEX_OFS_E1_DIR_HI
        |=> e1_pin_oe_o[15:8] == $past(reg_wdata_i))
        else $error("high direction write did not reach pins 8 to 15");

    // The low input read returns the lines of the read cycle.
    e2_lo_read_a: assert property (
        clk_en_i && reg_rd_i && reg_addr_i == `BGEX_OFS_E2_IN_LO
        |=> reg_rdata_o == {1'b0, $past(processor_pll_lock_i),
                            $past(lock_indicator_lamp_i),
                            $past(processor_line_sixteen_i),
                            $past(programming_voltage_enable_i),
                            $past(satellite_receiver_enable_i), 2'b00})
        else $error("second expander low input read wrong");

    // The high input read returns protect, detect, identifier and serial lines.
    e2_hi_read_a: assert property (
        clk_en_i && reg_rd_i && reg_addr_i == `BGEX_OFS_E2_IN_HI
        |=> reg_rdata_o == {$past(external_serial_data_line_i),
                            $past(external_serial_clock_line_i),
                            $past(expansion_board_ident_2_i),
                            $past(expansion_board_ident_1_i),
                            $past(expansion_board_ident_0_i),
                            $past(expansion_board_detect_i),
                            $past(eeprom_write_protect_n_i),
                            $past(nand_write_protect_n_i)})
        else $error("second expander high input read wrong");

    // The first expander high input read shows the pad level of the read cycle.
    e1_live_read_a: assert property (
        clk_en_i && reg_rd_i && reg_addr_i == `BGEX_OFS_E1_IN_HI
        |=> reg_rdata_o == $past(e1_pin_i[15:8]))
        else $error("input read not the live pin level");

    // The low input byte also shows the pad level of the read cycle.
    e1_lo_read_a: assert property (
        clk_en_i && reg_rd_i && reg_addr_i == `BGEX_OFS_E1_IN_LO
        |=> reg_rdata_o == $past(e1_pin_i[7:0]))
        else $error("low input read not the live pin level");

    // A low direction write updates the low pin enables.
    dir_lo_write_a: assert property (
        clk_en_i && reg_wr_i && reg_addr_i == `BGEX_OFS_E1_DIR_LO
        |=> e1_pin_oe_o[7:0] == $past(reg_wdata_i))
        else $error("low direction write did not reach pins 0 to 7");

    // A low output write sets the level of the low pins that drive.
    out_lo_write_a: assert property (
        clk_en_i && reg_wr_i && reg_addr_i == `BGEX_OFS_E1_OUT_LO
        |=> (e1_pin_o[7:0] & e1_pin_oe_o[7:0]) ==
            ($past(reg_wdata_i) & e1_pin_oe_o[7:0]))
        else $error("low output write did not reach the driving pins");

    // With no read strobe the read data fall back to zero on the next enabled edge.
    rdata_idle_zero_a: assert property (
        clk_en_i && !reg_rd_i |=> reg_rdata_o == `BGEX_RSVD_VAL)
        else $error("read data did not return to zero");

    // Offsets beyond the map read as zero, so software can probe safely.
    unmapped_read_zero_a: assert property (
        clk_en_i && reg_rd_i && reg_addr_i > `BGEX_OFS_E2_IN_HI
        |=> reg_rdata_o == `BGEX_RSVD_VAL)
        else $error("unmapped offset read not zero");

    // Writing an input register leaves the direction and output bytes alone.
    ro_write_inert_a: assert property (
        reg_wr_i && (reg_addr_i == `BGEX_OFS_E2_IN_LO ||
                     reg_addr_i == `BGEX_OFS_E2_IN_HI ||
                     reg_addr_i == `BGEX_OFS_E1_IN_LO ||
                     reg_addr_i == `BGEX_OFS_E1_IN_HI)
        |=> $stable({dir_hi, dir_lo, out_hi, out_lo}))
        else $error("write to an input register changed state");

    // A low clock enable freezes the read data and every register.
    freeze_hold_a: assert property (
        !clk_en_i |=> $stable({reg_rdata_o, dir_hi, dir_lo, out_hi, out_lo}))
        else $error("state moved while clock enable low");

    // Scenarios of interest.
    dir_then_read_c: cover property (
        (clk_en_i && reg_wr_i && reg_addr_i == `BGEX_OFS_E1_DIR_HI) ##1
        (clk_en_i && reg_rd_i && reg_addr_i == `BGEX_OFS_E1_DIR_HI));
    ident_read_c: cover property (
        clk_en_i && reg_rd_i && reg_addr_i == `BGEX_OFS_E2_IN_HI &&
        expansion_board_ident_2_i && !expansion_board_ident_0_i);
    all_output_c: cover property (e1_pin_oe_o == 16'hFFFF);
    frozen_write_c: cover property (!clk_en_i && reg_wr_i);
    unmapped_read_c: cover property (
        clk_en_i && reg_rd_i && reg_addr_i > `BGEX_OFS_E2_IN_HI);

endmodule

// *** test/bgex_board_model.sv ***
`timescale 1ns/1ns

// Board side of the first expander pads; no pull on them, so a pad the
// block does not drive shows whatever the external source puts there.
module bgex_board_model #(
    parameter int PIN_W = 16
) (
    // Block side of each pad.
    input  wire logic [PIN_W-1:0] drv_i,
    input  wire logic [PIN_W-1:0] drv_en_i,
    // External source and resolved pad level.
    input  wire logic [PIN_W-1:0] ext_lvl_i,
    output logic      [PIN_W-1:0] pad_o
);
    // A driving pin wins its pad, otherwise the external level shows.
    assign pad_o = (drv_en_i & drv_i) | (~drv_en_i & ext_lvl_i);
endmodule

// *** test/board_gpio_expander_regs_tb.sv ***
`timescale 1ns/1ns
`include "bgex_defs.svh"

module board_gpio_expander_regs_tb
    import bgex_pkg::*;
;
    logic        clock_i = 0;
    logic        rst_b_i = 1;
    logic        clk_en_i = 1;
    logic        reg_wr_i = 0;
    logic        reg_rd_i = 0;
    bgex_byte_t  reg_addr_i = 0;
    bgex_byte_t  reg_wdata_i = 0;
    bgex_byte_t  reg_rdata_o;
    logic [15:0] e1_pin_i;
    logic [15:0] e1_pin_o;
    logic [15:0] e1_pin_oe_o;
    logic [15:0] ext = 0;
    logic [4:0]  slo = 0;
    logic [7:0]  shi = 0;
    bgex_byte_t  dl = 0;
    bgex_byte_t  dh = 0;
    bgex_byte_t  ol = 0;
    bgex_byte_t  oh = 0;
    bgex_byte_t  q[$];
    bgex_byte_t  ro[4] = '{`BGEX_OFS_E1_IN_LO, `BGEX_OFS_E1_IN_HI,
                           `BGEX_OFS_E2_IN_LO, `BGEX_OFS_E2_IN_HI};
    logic        rd_pend = 0;
    logic        en_d = 0;
    int          errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    // Free-running 100 MHz clock.
    always #5 clock_i = ~clock_i;

    bgex_top #(.PIN_W(16)) bgex_top_i (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .e1_pin_i(e1_pin_i), .e1_pin_o(e1_pin_o), .e1_pin_oe_o(e1_pin_oe_o),
        .satellite_receiver_enable_i(slo[0]), .programming_voltage_enable_i(slo[1]),
        .processor_line_sixteen_i(slo[2]), .lock_indicator_lamp_i(slo[3]),
        .processor_pll_lock_i(slo[4]), .nand_write_protect_n_i(shi[0]),
        .eeprom_write_protect_n_i(shi[1]), .expansion_board_detect_i(shi[2]),
        .expansion_board_ident_0_i(shi[3]), .expansion_board_ident_1_i(shi[4]),
        .expansion_board_ident_2_i(shi[5]), .external_serial_clock_line_i(shi[6]),
        .external_serial_data_line_i(shi[7]));

    bgex_board_model #(.PIN_W(16)) bgex_board_model_i (
        .drv_i(e1_pin_o), .drv_en_i(e1_pin_oe_o), .ext_lvl_i(ext), .pad_o(e1_pin_i));

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Read value worked out from the mirror and the board levels.
    function automatic bgex_byte_t exp_rd(bgex_byte_t a);
        case (a)
            `BGEX_OFS_E1_IN_LO:  return (dl & ol) | (~dl & ext[7:0]);
            `BGEX_OFS_E1_IN_HI:  return (dh & oh) | (~dh & ext[15:8]);
            `BGEX_OFS_E1_OUT_LO: return ol;
            `BGEX_OFS_E1_OUT_HI: return oh;
            `BGEX_OFS_E1_DIR_LO: return dl;
            `BGEX_OFS_E1_DIR_HI: return dh;
            `BGEX_OFS_E2_IN_LO:  return {1'b0, slo, 2'b00};
            `BGEX_OFS_E2_IN_HI:  return shi;
            default:             return `BGEX_RSVD_VAL;
        endcase
    endfunction

    // One strobe cycle; a read notes its expected answer for the monitor.
    task automatic op(bit wr, bgex_byte_t a, bgex_byte_t d);
        reg_wr_i <= wr;
        reg_rd_i <= !wr;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        if (!wr && clk_en_i)
            q.push_back(exp_rd(a));
        @(posedge clock_i);
        if (wr && clk_en_i) begin
            case (a)
                `BGEX_OFS_E1_OUT_LO: ol = d;
                `BGEX_OFS_E1_OUT_HI: oh = d;
                `BGEX_OFS_E1_DIR_LO: dl = d;
                `BGEX_OFS_E1_DIR_HI: dh = d;
                default: ;
            endcase
        end
    endtask

    task automatic idle();
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        @(posedge clock_i);
    endtask

    // New random board levels; held stable across the reads that follow.
    task automatic shake();
        logic [31:0] r;
        r = $urandom;
        ext <= r[15:0];
        slo <= r[20:16];
        shi <= r[28:21];
        idle();
    endtask

    task automatic read_all();
        for (int a = 0; a < 8; a++)
            op(0, 8'(a), 8'h00);
    endtask

    // Strobe bookkeeping and the hang guard.
    always @(posedge clock_i) begin
        rd_pend <= rst_b_i && clk_en_i && reg_rd_i;
        en_d <= clk_en_i;
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            errors++;
            end_sim();
        end
    end

    // Outputs are judged mid-cycle, once the edge's updates have settled.
    always @(negedge clock_i) begin
        if (!rst_b_i) begin
            check("pin_oe_reset", e1_pin_oe_o, 16'h0000);
        end else begin
            check("pin_oe", e1_pin_oe_o, {dh, dl});
            check("pin_out", e1_pin_o, {oh & dh, ol & dl});
            if (rd_pend)
                check("rdata", reg_rdata_o, q.pop_front());
            else if (en_d)
                check("rdata_idle", reg_rdata_o, 8'h00);
        end
    end

    // Reset falls as a real edge at time zero so the asynchronous branches act
    // before the first clock and no register is unknown at that edge.
    initial begin
        rst_b_i <= 1'b0;
        void'($urandom(85919));
        repeat (6) @(posedge clock_i);
        rst_b_i <= 1'b1;
        idle();
        read_all();
        // Random traffic, back to back, with writes aimed at read-only places.
        repeat (24) begin
            shake();
            for (int a = 2; a < 6; a++)
                op(1, 8'(a), 8'($urandom));
            foreach (ro[i])
                op(1, ro[i], ~exp_rd(ro[i]));
            op(1, 8'($urandom_range(8, 255)), 8'hFF);
            read_all();
            op(0, 8'($urandom_range(8, 255)), 8'h00);
        end
        // A frozen clock enable drops strobes and holds the read data.
        op(0, `BGEX_OFS_E1_DIR_HI, 8'h00);
        clk_en_i <= 1'b0;
        idle();
        op(1, `BGEX_OFS_E1_DIR_HI, ~dh);
        op(0, `BGEX_OFS_E1_DIR_LO, 8'h00);
        clk_en_i <= 1'b1;
        idle();
        op(0, `BGEX_OFS_E1_DIR_HI, 8'h00);
        // Each direction byte written and read back to back, then all pins driving.
        op(1, `BGEX_OFS_E1_DIR_LO, 8'hFF);
        op(0, `BGEX_OFS_E1_DIR_LO, 8'h00);
        op(1, `BGEX_OFS_E1_DIR_HI, 8'hFF);
        op(0, `BGEX_OFS_E1_DIR_HI, 8'h00);
        read_all();
        idle();
        // Reset in mid-run returns every direction to input.
        rst_b_i <= 1'b0;
        {dl, dh, ol, oh} = '0;
        idle();
        idle();
        rst_b_i <= 1'b1;
        idle();
        read_all();
        idle();
        end_sim();
    end
endmodule
